// ==== rtl/ptpio_pkg.sv ====
// Operation
// - A timed wait halts the issuing program for 1 to 9900 ticks of 10 ms, then releases it.
// - A timed wait that expires normally raises its timeout bit before the program moves on.
// - A cancel naming another program ends any pending timed, port or read wait in that program.
// - A port or read wait without a timeout runs an unlimited timer that a cancel still ends.
// - A free-running time counter advances every 10 ms and is returned on a get-time command.
// - The time counter has no defined origin; programs use only differences of two readings.
// - The bit-range command sets, clears or inverts every bit from the first to the last index.
// - An on-pulse sets its bit at once and clears it when its timer expires.
// - Pulse durations are 1 to 9900 ticks of 10 ms.
// - An on-pulse to a bit already on still clears it at expiry.
// - When the issuing program ends, its pulse timers are dropped and bits stay as pulsed.
// - A cancel never touches pulse timers.
// - Each program owns at most 16 pulse timers, reusable without limit.
// - An off-pulse clears its bit at once and sets it again when its timer expires.
// - A port wait with a timeout aborts at expiry and raises its timeout bit only then.
package ptpio_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TIME_MIN_TICKS = 1;
	localparam int TIME_MAX_TICKS = 9900;
	localparam int TIME_W = 14;
	localparam int SYSTIME_W = 32;
	localparam int PULSE_SLOTS = 16;
	// Bit-range variants
	typedef enum logic [1:0] {
		PTPIO_BR_SET = 2'h0,
		PTPIO_BR_CLEAR = 2'h1,
		PTPIO_BR_INVERT = 2'h2
	} ptpio_bitop_e;
	// Wait states, Gray along idle->wait->done
	typedef enum logic [1:0] {
		PTPIO_W_IDLE = 2'h0,
		PTPIO_W_RUN = 2'h1,
		PTPIO_W_DONE = 2'h3
	} ptpio_wait_e;
endpackage

// ==== rtl/ptpio_tick.sv ====
`timescale 1ns/10ps
`default_nettype none
// 10 ms tick generator and free-running system time
module ptpio_tick #(
	parameter int TICK_CYCLES = ptpio_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	output logic tick,
	output logic [ptpio_pkg::SYSTIME_W-1:0] systime
);
	typedef struct packed {
		logic [31:0] div;
		logic tick;
		logic [ptpio_pkg::SYSTIME_W-1:0] systime;
	} ptpio_tick_s;
	ptpio_tick_s st, next_st;
	// Divider wraps once per tick period; time counter advances on it
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.div == 32'(TICK_CYCLES - 1)) begin
			next_st.div = 32'h0;
			next_st.tick = 1'b1;
			next_st.systime = st.systime + 32'h1;
		end else begin
			next_st.div = st.div + 32'h1;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign tick = st.tick;
	assign systime = st.systime;
endmodule
`default_nettype wire

// ==== rtl/ptpio_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Wait timers, cancel, system time, bit-range ops and pulse timers for N programs
module ptpio_top #(
	parameter int NPROG = 4,
	parameter int NBITS = 64,
	parameter int IDX_W = 6,
	parameter int PROG_W = 2,
	parameter int TICK_CYCLES = ptpio_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Wait command (timed wait, port wait, read wait)
	input wire logic WAIT_CMD,
	input wire logic [PROG_W-1:0] WAIT_PROG,
	input wire logic WAIT_TIMED,
	input wire logic WAIT_HAS_TIMEOUT,
	input wire logic [ptpio_pkg::TIME_W-1:0] WAIT_TICKS,
	input wire logic [NPROG-1:0] WAIT_COND_MET,
	// Wait status per program
	output logic [NPROG-1:0] WAIT_BUSY,
	output logic [NPROG-1:0] WAIT_RELEASE,
	output logic [NPROG-1:0] TIMEOUT_OUT_BIT,
	// Cancel and program end
	input wire logic CANCEL_CMD,
	input wire logic [PROG_W-1:0] CANCEL_PROG,
	input wire logic [NPROG-1:0] PROG_END,
	// Get system time
	input wire logic GET_TIME_CMD,
	output logic [ptpio_pkg::SYSTIME_W-1:0] TIME_VALUE,
	output logic TIME_VALID,
	// Bit-range operation
	input wire logic BIT_OP_CMD,
	input wire logic [1:0] BIT_OP_KIND,
	input wire logic [IDX_W-1:0] BIT_FIRST,
	input wire logic [IDX_W-1:0] BIT_LAST,
	// Pulse commands
	input wire logic PULSE_CMD,
	input wire logic PULSE_ON,
	input wire logic [PROG_W-1:0] PULSE_PROG,
	input wire logic [IDX_W-1:0] PULSE_BIT,
	input wire logic [ptpio_pkg::TIME_W-1:0] PULSE_TICKS,
	output logic PULSE_ACCEPT,
	// Outputs and flags
	output logic [NBITS-1:0] OUT_BITS
);
	localparam int NSLOT = NPROG * ptpio_pkg::PULSE_SLOTS;
	localparam int TW = ptpio_pkg::TIME_W;

	typedef struct packed {
		ptpio_pkg::ptpio_wait_e [NPROG-1:0] wst;
		logic [NPROG-1:0][TW-1:0] wcnt;
		logic [NPROG-1:0] wtimed;
		logic [NPROG-1:0] wlimited;
		logic [NPROG-1:0] wrel;
		logic [NPROG-1:0] tout;
		logic [NSLOT-1:0] pact;
		logic [NSLOT-1:0] plevel;
		logic [NSLOT-1:0][IDX_W-1:0] pbit;
		logic [NSLOT-1:0][TW-1:0] pcnt;
		logic [NBITS-1:0] outs;
		logic [ptpio_pkg::SYSTIME_W-1:0] tval;
		logic tvalid;
		logic paccept;
	} ptpio_state_s;

	ptpio_state_s st, next_st;
	logic tick;
	logic [ptpio_pkg::SYSTIME_W-1:0] systime;

	// Clamp a duration into the legal tick range
	function automatic logic [TW-1:0] clamp_ticks(input logic [TW-1:0] t);
		if (t < TW'(ptpio_pkg::TIME_MIN_TICKS)) begin
			return TW'(ptpio_pkg::TIME_MIN_TICKS);
		end else if (t > TW'(ptpio_pkg::TIME_MAX_TICKS)) begin
			return TW'(ptpio_pkg::TIME_MAX_TICKS);
		end
		return t;
	endfunction

	// True when a command's program field names program p
	function automatic logic prog_hit(input logic [PROG_W-1:0] sel, input int p);
		return sel == PROG_W'(p);
	endfunction

	// Flat index of the k-th pulse timer of a program
	function automatic int slot_of(input logic [PROG_W-1:0] prog, input int k);
		return int'(prog) * ptpio_pkg::PULSE_SLOTS + k;
	endfunction

	// Shared 10 ms tick and free-running time
	ptpio_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(CLK),
		.reset(RESET),
		.tick(tick),
		.systime(systime)
	);

	// Next state of wait machines, time snapshot, bit operations and pulse timers
	always_comb begin
		logic found;
		logic [IDX_W-1:0] b;
		found = 1'b0;
		b = '0;
		next_st = st;
		next_st.wrel = '0;
		next_st.tvalid = 1'b0;
		next_st.paccept = 1'b0;
		// Wait timers per program
		for (int p = 0; p < NPROG; p++) begin
			case (st.wst[p])
				ptpio_pkg::PTPIO_W_IDLE: begin
					if (WAIT_CMD && prog_hit(WAIT_PROG, p)) begin
						next_st.wst[p] = ptpio_pkg::PTPIO_W_RUN;
						next_st.wcnt[p] = clamp_ticks(WAIT_TICKS);
						next_st.wtimed[p] = WAIT_TIMED;
						next_st.wlimited[p] = WAIT_TIMED | WAIT_HAS_TIMEOUT;
						next_st.tout[p] = 1'b0;
					end
				end
				ptpio_pkg::PTPIO_W_RUN: begin
					// Cancel first: it beats condition and timeout in the same cycle
					if (CANCEL_CMD && prog_hit(CANCEL_PROG, p)) begin
						next_st.wst[p] = ptpio_pkg::PTPIO_W_DONE;
					end else if (PROG_END[p]) begin
						next_st.wst[p] = ptpio_pkg::PTPIO_W_IDLE;
					end else if (!st.wtimed[p] && WAIT_COND_MET[p]) begin
						next_st.wst[p] = ptpio_pkg::PTPIO_W_DONE;
					end else if (tick && st.wlimited[p]) begin
						if (st.wcnt[p] == TW'(1)) begin
							next_st.tout[p] = 1'b1;
							next_st.wst[p] = ptpio_pkg::PTPIO_W_DONE;
						end else begin
							next_st.wcnt[p] = st.wcnt[p] - TW'(1);
						end
					end
				end
				ptpio_pkg::PTPIO_W_DONE: begin
					next_st.wrel[p] = 1'b1;
					next_st.wst[p] = ptpio_pkg::PTPIO_W_IDLE;
				end
				default: next_st.wst[p] = ptpio_pkg::PTPIO_W_IDLE;
			endcase
		end
		// Get-time snapshot
		if (GET_TIME_CMD) begin
			next_st.tval = systime;
			next_st.tvalid = 1'b1;
		end
		// Pulse expiry and program-end drop
		for (int s = 0; s < NSLOT; s++) begin
			if (st.pact[s]) begin
				if (PROG_END[s / ptpio_pkg::PULSE_SLOTS]) begin
					// Owner ended: forget the timer, keep the bit as pulsed
					next_st.pact[s] = 1'b0;
				end else if (tick) begin
					if (st.pcnt[s] == TW'(1)) begin
						next_st.pact[s] = 1'b0;
						next_st.outs[st.pbit[s]] = ~st.plevel[s];
					end else begin
						next_st.pcnt[s] = st.pcnt[s] - TW'(1);
					end
				end
			end
		end
		// Bit-range operation
		// An empty range (first above last) changes nothing
		if (BIT_OP_CMD) begin
			for (int i = 0; i < NBITS; i++) begin
				if (IDX_W'(i) >= BIT_FIRST && IDX_W'(i) <= BIT_LAST) begin
					case (BIT_OP_KIND)
						ptpio_pkg::PTPIO_BR_SET: next_st.outs[i] = 1'b1;
						ptpio_pkg::PTPIO_BR_CLEAR: next_st.outs[i] = 1'b0;
						ptpio_pkg::PTPIO_BR_INVERT: next_st.outs[i] = ~st.outs[i];
						default: next_st.outs[i] = st.outs[i];
					endcase
				end
			end
		end
		// New pulse takes the lowest free slot of its program
		if (PULSE_CMD) begin
			for (int k = 0; k < ptpio_pkg::PULSE_SLOTS; k++) begin
				if (!found && !next_st.pact[slot_of(PULSE_PROG, k)]) begin
					found = 1'b1;
					b = PULSE_BIT;
					next_st.pact[slot_of(PULSE_PROG, k)] = 1'b1;
					next_st.plevel[slot_of(PULSE_PROG, k)] = PULSE_ON;
					next_st.pbit[slot_of(PULSE_PROG, k)] = b;
					next_st.pcnt[slot_of(PULSE_PROG, k)] =
						clamp_ticks(PULSE_TICKS);
				end
			end
			// A full program drops the command and raises no accept
			if (found) begin
				next_st.outs[b] = PULSE_ON;
				next_st.paccept = 1'b1;
			end
		end
	end

	// Register the whole state
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	always_comb begin
		for (int p = 0; p < NPROG; p++) begin
			WAIT_BUSY[p] = (st.wst[p] != ptpio_pkg::PTPIO_W_IDLE);
		end
	end
	assign WAIT_RELEASE = st.wrel;
	assign TIMEOUT_OUT_BIT = st.tout;
	assign TIME_VALUE = st.tval;
	assign TIME_VALID = st.tvalid;
	assign PULSE_ACCEPT = st.paccept;
	assign OUT_BITS = st.outs;
endmodule
`default_nettype wire

// ==== testbench/ptpio_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module ptpio_checker #(
	parameter int NPROG = 4
) (
	// Clock, reset, commands
	input wire logic CLK,
	input wire logic RESET,
	input wire logic WAIT_CMD,
	input wire logic GET_TIME_CMD,
	input wire logic PULSE_CMD,
	// Answers
	input wire logic [NPROG-1:0] WAIT_BUSY,
	input wire logic [NPROG-1:0] WAIT_RELEASE,
	input wire logic [NPROG-1:0] TIMEOUT_OUT_BIT,
	input wire logic TIME_VALID,
	input wire logic PULSE_ACCEPT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// Timeout flag then release one cycle on
	sequence s_flag_rel;
		TIMEOUT_OUT_BIT[0] ##1 WAIT_RELEASE[0];
	endsequence
	a_time_reply: assert property (GET_TIME_CMD |=> TIME_VALID) else $error("time");
	a_time_cause: assert property (TIME_VALID |-> $past(GET_TIME_CMD)) else $error("time");
	a_pulse_cause: assert property (PULSE_ACCEPT |-> $past(PULSE_CMD)) else $error("acc");
	a_acc_once: assert property (PULSE_ACCEPT && !PULSE_CMD |=> !PULSE_ACCEPT) else $error("acc");
	a_wait_start: assert property (WAIT_CMD && !WAIT_BUSY |=> |WAIT_BUSY) else $error("busy");
	a_rel_once: assert property (WAIT_RELEASE[0] |=> !WAIT_RELEASE[0]) else $error("rel");
	a_rel_busy: assert property (WAIT_RELEASE[0] |-> $past(WAIT_BUSY[0])) else $error("rel");
	a_tmo_rel: assert property ($rose(TIMEOUT_OUT_BIT[0]) |-> s_flag_rel) else $error("tmo");
endmodule
`default_nettype wire

// ==== testbench/ptpio_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module ptpio_partner (
	// Clock and wait status
	input wire logic clk,
	input wire logic [3:0] busy,
	// Port levels
	output logic [3:0] cond
);
	logic [4:0] cnt = 5'h00;
	// Only program 3 sees its port, slowly
	always @(posedge clk) begin
		cnt <= busy[3] ? cnt + 5'h01 : 5'h00;
	end
	assign cond = {cnt[4] & busy[3], 3'h0};
endmodule
`default_nettype wire

// ==== testbench/test_ptpio.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_ptpio;
	logic clk = 0, reset = 1, wc = 0, cc = 0, tc = 0, bc = 0, pc = 0, wm = 0, wo = 0, po = 0;
	logic [1:0] wp = 0, cp = 0, bk = 0, pp = 0;
	logic [5:0] bf = 0, bl = 0, pb = 0;
	logic [13:0] wt = 0, pt = 0;
	logic [3:0] pend = 0, cond, busy, rel, tmo;
	logic [31:0] tval, t0;
	logic [63:0] bits;
	logic tv, pacc;
	int err_total = 0, cmp_count = 0, n;
	ptpio_top #(.TICK_CYCLES(10)) u_dut (.CLK(clk), .RESET(reset), .WAIT_CMD(wc),
		.WAIT_PROG(wp), .WAIT_TIMED(wm), .WAIT_HAS_TIMEOUT(wo), .WAIT_TICKS(wt),
		.WAIT_COND_MET(cond), .WAIT_BUSY(busy), .WAIT_RELEASE(rel), .TIMEOUT_OUT_BIT(tmo),
		.CANCEL_CMD(cc), .CANCEL_PROG(cp), .PROG_END(pend), .GET_TIME_CMD(tc),
		.TIME_VALUE(tval), .TIME_VALID(tv), .BIT_OP_CMD(bc), .BIT_OP_KIND(bk),
		.BIT_FIRST(bf), .BIT_LAST(bl), .PULSE_CMD(pc), .PULSE_ON(po), .PULSE_PROG(pp),
		.PULSE_BIT(pb), .PULSE_TICKS(pt), .PULSE_ACCEPT(pacc), .OUT_BITS(bits));
	ptpio_partner u_seq (.clk(clk), .busy(busy), .cond(cond));
	// 100 MHz clock
	always #5 clk = ~clk;
	// Compares one value
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Issues a command; s is {wait, cancel, time, bits, pulse}
	task automatic cmd(input logic [4:0] s, input logic [1:0] p, input logic [1:0] m,
		input logic [13:0] t = 14'h0, input logic [5:0] f = 6'h0, input logic [5:0] l = 6'h0);
		@(posedge clk);
		{wc, cc, tc, bc, pc} <= s;
		{wp, cp, bk, pp} <= {4{p}};
		{wm, po, wo} <= {m[1], m};
		{wt, pt, bf, pb, bl} <= {t, t, f, f, l};
		@(posedge clk);
		{wc, cc, tc, bc, pc} <= 5'h00;
		#1;
	endtask
	// Counts cycles up to a release
	task automatic wrel(input int p);
		for (n = 0; rel[p] !== 1'b1 && n < 400; n++) begin
			@(posedge clk);
			#1;
		end
	endtask
	// Timed wait, wait with timeout, unlimited port wait
	task automatic t_wait();
		cmd(5'h10, 2'h0, 2'h2, 14'h3);
		wrel(0);
		chk({n > 20 && n < 34, tmo[0]}, 2'h3);
		cmd(5'h10, 2'h0, 2'h1, 14'h2);
		wrel(0);
		chk(tmo[0], 1'b1);
		cmd(5'h10, 2'h3, 2'h0, 14'h1);
		wrel(3);
		chk({n > 15, tmo[3]}, 2'h2);
	endtask
	// Cancel ends a port wait but spares a pulse
	task automatic t_cancel();
		cmd(5'h01, 2'h0, 2'h2, 14'h9, 6'ha);
		chk({pacc, bits[10]}, 2'h3);
		cmd(5'h10, 2'h1, 2'h0);
		repeat (40) @(posedge clk);
		chk(busy[1], 1'b1);
		cmd(5'h08, 2'h1, 2'h0);
		wrel(1);
		chk({n, tmo[1]}, 6'h02);
		cmd(5'h10, 2'h2, 2'h2, 14'h64);
		cmd(5'h08, 2'h2, 2'h0);
		wrel(2);
		chk({n, tmo[2]}, 6'h02);
		cmd(5'h08, 2'h0, 2'h0);
		chk(bits[10], 1'b1);
		repeat (60) @(posedge clk);
		chk(bits[10], 1'b0);
	endtask
	// Two time readings 50 cycles apart
	task automatic t_time();
		cmd(5'h04, 2'h0, 2'h0);
		t0 = tval;
		repeat (48) @(posedge clk);
		cmd(5'h04, 2'h0, 2'h0);
		chk({tv, tval - t0}, 33'h100000005);
	endtask
	// Clear, set, invert, empty range
	task automatic t_bits();
		cmd(5'h02, 2'h1, 2'h0, 14'h0, 6'h00, 6'h3f);
		chk(bits, 64'h0);
		cmd(5'h02, 2'h0, 2'h0, 14'h0, 6'h04, 6'h14);
		cmd(5'h02, 2'h2, 2'h0, 14'h0, 6'h06, 6'h09);
		cmd(5'h02, 2'h0, 2'h0, 14'h0, 6'h16, 6'h15);
		chk(bits, 64'h1ffc30);
	endtask
	// Pulses on a set bit, slot limit, program end
	task automatic t_pulse();
		cmd(5'h01, 2'h2, 2'h2, 14'h3, 6'h14);
		cmd(5'h01, 2'h2, 2'h0, 14'h3, 6'h13);
		chk(bits[20:19], 2'h2);
		repeat (40) @(posedge clk);
		chk(bits[20:19], 2'h1);
		for (int i = 0; i < 17; i++) begin
			cmd(5'h01, 2'h2, 2'h2, 14'h14, 6'h1e + 6'(i));
			chk({pacc, bits[30 + i]}, {2{i < 16}});
		end
		@(posedge clk);
		pend <= 4'h4;
		@(posedge clk);
		pend <= 4'h0;
		repeat (250) @(posedge clk);
		chk(bits[45:30], 16'hffff);
		cmd(5'h01, 2'h2, 2'h2, 14'h1);
		chk(pacc, 1'b1);
	endtask
	// Prints counts and verdict
	task automatic stop_test();
		$display("cmp %0d err %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Reset, then scenarios
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		t_wait();
		t_cancel();
		t_time();
		t_bits();
		t_pulse();
		stop_test();
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		stop_test();
	end
endmodule
bind ptpio_top ptpio_checker #(.NPROG(NPROG)) u_chk (.*);
`default_nettype wire
